// file: rtl/sdram_timing_defines.svh
// timing counts, field positions and command codes for the sdram link
`ifndef SDRAM_TIMING_DEFINES_SVH
`define SDRAM_TIMING_DEFINES_SVH
`define CLK_MHZ 100
// least time in ns to whole cycles, rounded up, never below one
`define CYC_MIN(ns) (((((ns) * `CLK_MHZ) + 999) / 1000) < 1 ? 1 : ((((ns) * `CLK_MHZ) + 999) / 1000))
// slowest grade figures, so any grade is safe
`define T_RCD_NS 20
`define T_RRD_NS 15
`define T_RP_NS 20
`define T_RAS_NS 42
`define T_RC_NS 70
`define T_RFC_NS 70
`define T_RCD `CYC_MIN(`T_RCD_NS)
`define T_RRD `CYC_MIN(`T_RRD_NS)
`define T_RP `CYC_MIN(`T_RP_NS)
`define T_RAS `CYC_MIN(`T_RAS_NS)
`define T_RC `CYC_MIN(`T_RC_NS)
`define T_RFC `CYC_MIN(`T_RFC_NS)
`define T_DAL2 4
`define T_DPL 3
`define T_RDL 2
`define T_BDL 1
`define T_CDL 1
`define T_CCD 1
`define T_MRD 2
`define T_PED 1
`define T_DQZ 2
`define T_INIT_US 100
`define INIT_CYC (`T_INIT_US * `CLK_MHZ)
`define REF_ROWS 4096
`define T_REF_MS 64
`define T_REF_AT_MS 16
// refresh spacing per row, rounded down
`define REF_INT_CYC ((`T_REF_MS * 1000000 / `REF_ROWS) * `CLK_MHZ / 1000)
`define REF_INT_AT_CYC ((`T_REF_AT_MS * 1000000 / `REF_ROWS) * `CLK_MHZ / 1000)
`define CAS_LAT 2
`define MR_BL_LSB 0
`define MR_CL_LSB 4
`define AP_BIT 10
`define MODE_OP 12'h020
// {ras_n, cas_n, we_n}
`define CMD_LMR 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_ACT 3'h3
`define CMD_WR 3'h4
`define CMD_RD 3'h5
`define CMD_BST 3'h6
`define CMD_NOP 3'h7
`endif

// file: rtl/sdram_timing_pkg.sv
// types used by the controller end of the sdram link; the memory end imports them but uses none
package sdram_timing_pkg;
  typedef logic [2:0] cmd_t;
  typedef enum logic [2:0] {
    ST_POWER, ST_REF, ST_LMR, ST_IDLE, ST_RW, ST_SLEEP
  } ctrl_state_e;
endpackage

// file: rtl/sdram_bus_if.sv
// pin bundle between controller and memory ends
`timescale 1ns/1ns
interface sdram_bus_if;
  logic cke; // clock enable
  logic cs_n; // chip select, active low
  logic [2:0] cmd; // {ras_n, cas_n, we_n}
  logic [1:0] ba; // bank
  logic [11:0] addr; // row, column or op-code
  logic [3:0] dqm; // byte masks
  logic [31:0] c_dq; // controller data out
  logic c_dq_oe; // controller drives dq
  logic [31:0] m_dq; // memory data out
  logic [3:0] m_dq_oe; // memory drives lane
  logic [31:0] dq_bus; // resolved wire level
  // resolve the shared data wire; undriven lanes read low
  assign dq_bus = c_dq_oe ? c_dq : (m_dq & {{8{m_dq_oe[3]}}, {8{m_dq_oe[2]}},
                                             {8{m_dq_oe[1]}}, {8{m_dq_oe[0]}}});
  modport ctrl (output cke, cs_n, cmd, ba, addr, dqm, c_dq, c_dq_oe, input dq_bus);
  modport mem (input cke, cs_n, cmd, ba, addr, dqm, dq_bus, output m_dq, m_dq_oe);
endinterface

// file: rtl/sdram_mem_end.sv
// memory end: command decode, bursts, masks and output timing
`timescale 1ns/1ns
`include "sdram_timing_defines.svh"
module sdram_mem_end import sdram_timing_pkg::*; (
  input wire logic mclk_i,
  input wire logic nrst_i,
  sdram_bus_if.mem bus,
  output logic [3:0] bank_open_o,
  output logic power_down_o,
  output logic [2:0] cas_lat_o
);
  logic cke_r, cke_nxt; // cke sampled last edge
  logic [11:0] mode_r, mode_nxt; // mode register
  logic [3:0] open_r, open_nxt; // open row per bank
  logic bact_r, bact_nxt; // burst running
  logic [3:0] bcnt_r, bcnt_nxt; // words left
  logic [1:0] bbank_r, bbank_nxt;
  logic [1:0] bcol_r, bcol_nxt;
  logic bwr_r, bwr_nxt;
  logic bap_r, bap_nxt; // close row at end
  logic [31:0] mem_r [16]; // small store, rows folded
  logic [31:0] mem_nxt [16];
  logic [1:0] pv_r, pv_nxt; // read pipe valid
  logic [31:0] pd_r [2]; // read pipe data
  logic [31:0] pd_nxt [2];
  logic [3:0] dqmd_r, dqmd_nxt; // dqm one edge back
  logic [31:0] dq_r, dq_nxt;
  logic [3:0] oe_r, oe_nxt;

  // burst length code to words; full page not kept
  function automatic logic [3:0] bl_words(input logic [2:0] code);
    case (code)
      3'h1: bl_words = 4'h2;
      3'h2: bl_words = 4'h4;
      3'h3: bl_words = 4'h8;
      default: bl_words = 4'h1;
    endcase
  endfunction

  // next state of the whole memory end
  always_comb begin
    logic op; // word access this edge
    logic op_wr;
    logic [1:0] op_bank;
    logic [1:0] op_col;
    logic [2:0] cl;
    logic src_v;
    logic [31:0] src_d;
    logic [3:0] bl;
    op = 1'b0;
    op_wr = 1'b0;
    op_bank = bbank_r;
    op_col = bcol_r;
    cl = mode_r[`MR_CL_LSB +: 3];
    bl = bl_words(mode_r[`MR_BL_LSB +: 3]);
    src_v = 1'b0;
    src_d = '0;
    cke_nxt = bus.cke;
    mode_nxt = mode_r;
    open_nxt = open_r;
    bact_nxt = bact_r;
    bcnt_nxt = bcnt_r;
    bbank_nxt = bbank_r;
    bcol_nxt = bcol_r;
    bwr_nxt = bwr_r;
    bap_nxt = bap_r;
    mem_nxt = mem_r;
    pv_nxt = pv_r;
    pd_nxt = pd_r;
    dqmd_nxt = dqmd_r;
    dq_nxt = dq_r;
    oe_nxt = oe_r;
    // frozen while clock is suspended, one edge after cke low
    if (cke_r) begin
      dqmd_nxt = bus.dqm;
      // running burst advances unless a new command takes over
      if (bact_r) begin
        op = 1'b1;
        op_wr = bwr_r;
        bcnt_nxt = bcnt_r - 4'h1;
        bcol_nxt = bcol_r + 2'h1;
        if (bcnt_r == 4'h1) begin
          bact_nxt = 1'b0;
          if (bap_r) begin
            open_nxt[bbank_r] = 1'b0;
          end
        end
      end
      if (!bus.cs_n) begin
        case (bus.cmd)
          `CMD_RD, `CMD_WR: begin
            // column may change every cycle
            if (open_r[bus.ba]) begin
              op = 1'b1;
              op_wr = (bus.cmd == `CMD_WR);
              op_bank = bus.ba;
              op_col = bus.addr[1:0];
              bbank_nxt = bus.ba;
              bcol_nxt = bus.addr[1:0] + 2'h1;
              bwr_nxt = op_wr;
              bap_nxt = bus.addr[`AP_BIT];
              bcnt_nxt = bl - 4'h1;
              bact_nxt = (bl != 4'h1);
              if (bl == 4'h1 && bus.addr[`AP_BIT]) begin
                open_nxt[bus.ba] = 1'b0;
              end
            end else begin
              op = 1'b0;
            end
          end
          `CMD_ACT: open_nxt[bus.ba] = 1'b1;
          `CMD_PRE: begin
            if (bus.addr[`AP_BIT]) begin
              open_nxt = 4'h0;
            end else begin
              open_nxt[bus.ba] = 1'b0;
            end
            // cut burst; words in flight drain, lanes off cl edges later
            if (bact_r && (bus.addr[`AP_BIT] || bus.ba == bbank_r)) begin
              bact_nxt = 1'b0;
              op = 1'b0;
            end
          end
          `CMD_BST: begin
            bact_nxt = 1'b0;
            op = 1'b0;
          end
          `CMD_LMR: begin
            if (open_r == 4'h0) begin
              mode_nxt = bus.addr;
            end
          end
          default: ;
        endcase
      end
      // write mask applies to the word on the same edge
      if (op && op_wr) begin
        for (int i = 0; i < 4; i++) begin
          if (!bus.dqm[i]) begin
            mem_nxt[{op_bank, op_col}][8*i +: 8] = bus.dq_bus[8*i +: 8];
          end
        end
      end
      pv_nxt = {pv_r[0], op && !op_wr};
      pd_nxt[0] = mem_r[{op_bank, op_col}];
      pd_nxt[1] = pd_r[0];
      // pick the pipe stage that meets the read latency
      if (cl == 3'h1) begin
        src_v = op && !op_wr;
        src_d = mem_r[{op_bank, op_col}];
      end else if (cl == 3'h3) begin
        src_v = pv_r[1];
        src_d = pd_r[1];
      end else begin
        src_v = pv_r[0];
        src_d = pd_r[0];
      end
      dq_nxt = src_d;
      oe_nxt = {4{src_v}} & ~dqmd_r;
    end
  end

  // registers of the memory end
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cke_r <= 1'b1;
      mode_r <= `MODE_OP;
      open_r <= 4'h0;
      bact_r <= 1'b0;
      bcnt_r <= 4'h0;
      bbank_r <= 2'h0;
      bcol_r <= 2'h0;
      bwr_r <= 1'b0;
      bap_r <= 1'b0;
      pv_r <= 2'h0;
      dqmd_r <= 4'hf;
      dq_r <= 32'h0;
      oe_r <= 4'h0;
      bank_open_o <= 4'h0;
      power_down_o <= 1'b0;
      cas_lat_o <= 3'h2;
    end else begin
      cke_r <= cke_nxt;
      mode_r <= mode_nxt;
      open_r <= open_nxt;
      bact_r <= bact_nxt;
      bcnt_r <= bcnt_nxt;
      bbank_r <= bbank_nxt;
      bcol_r <= bcol_nxt;
      bwr_r <= bwr_nxt;
      bap_r <= bap_nxt;
      pv_r <= pv_nxt;
      dqmd_r <= dqmd_nxt;
      dq_r <= dq_nxt;
      oe_r <= oe_nxt;
      bank_open_o <= open_nxt;
      power_down_o <= !cke_nxt;
      cas_lat_o <= mode_nxt[`MR_CL_LSB +: 3];
    end
  end

  // storage needs no reset
  always_ff @(posedge mclk_i) begin
    mem_r <= mem_nxt;
    pd_r <= pd_nxt;
  end

  assign bus.m_dq = dq_r;
  assign bus.m_dq_oe = oe_r;
endmodule // sdram_mem_end

// file: rtl/sdram_ctrl_end.sv
// controller end: init, refresh, single-word accesses, power-down
`timescale 1ns/1ns
`include "sdram_timing_defines.svh"
module sdram_ctrl_end import sdram_timing_pkg::*; #(
  parameter int INIT_CYC = `INIT_CYC, // power-up pause
  parameter bit AT_GRADE = 1'b0 // shorter refresh period
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  sdram_bus_if.ctrl bus,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [21:0] addr_i, // {bank, row, col}
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wmask_i,
  input wire logic sleep_i,
  output logic ready_o,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic init_done_o
);
  localparam logic [11:0] REF_INT = AT_GRADE ? 12'(`REF_INT_AT_CYC) : 12'(`REF_INT_CYC);
  localparam int CAS = `CAS_LAT;

  function automatic int max3(input int a, input int b, input int c);
    int m;
    m = (a > b) ? a : b;
    max3 = (m > c) ? m : c;
  endfunction

  // spacing from the access command to the next activate or refresh
  localparam int T_POST = max3(`T_DAL2, `T_RC - `T_RCD, CAS + 1);

  ctrl_state_e st_r, st_nxt;
  logic [15:0] wait_r, wait_nxt; // cycles before next command
  logic [11:0] tmr_r, tmr_nxt; // refresh interval timer
  logic [1:0] pend_r, pend_nxt; // refreshes owed
  logic cke_r, cke_nxt;
  logic cs_n_r, cs_n_nxt;
  cmd_t cmd_r, cmd_nxt;
  logic [1:0] ba_r, ba_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic [3:0] dqm_r, dqm_nxt;
  logic [31:0] cdq_r, cdq_nxt;
  logic cdqoe_r, cdqoe_nxt;
  logic we_r, we_nxt; // held request
  logic [7:0] col_r, col_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0] wm_r, wm_nxt;
  logic [2:0] rcnt_r, rcnt_nxt; // read return countdown
  logic ready_nxt;
  logic [31:0] rdata_nxt;
  logic rvalid_nxt;
  logic done_nxt;

  // next command, timers and user outputs
  always_comb begin
    logic owe;
    owe = 1'b0;
    st_nxt = st_r;
    wait_nxt = (wait_r != 16'h0) ? wait_r - 16'h1 : wait_r;
    cke_nxt = cke_r;
    cs_n_nxt = 1'b0;
    cmd_nxt = `CMD_NOP;
    ba_nxt = ba_r;
    addr_nxt = addr_r;
    dqm_nxt = 4'h0;
    cdq_nxt = cdq_r;
    cdqoe_nxt = 1'b0;
    we_nxt = we_r;
    col_nxt = col_r;
    wd_nxt = wd_r;
    wm_nxt = wm_r;
    done_nxt = init_done_o;
    rvalid_nxt = 1'b0;
    rdata_nxt = rdata_o;
    rcnt_nxt = (rcnt_r != 3'h0) ? rcnt_r - 3'h1 : rcnt_r;
    // capture read word cas latency after the command edge
    if (rcnt_r == 3'h1) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = bus.dq_bus;
    end
    // one refresh owed per row interval, two at most
    tmr_nxt = tmr_r;
    if (st_r != ST_POWER) begin
      tmr_nxt = (tmr_r == 12'h0) ? REF_INT - 12'h1 : tmr_r - 12'h1;
      owe = (tmr_r == 12'h0);
    end
    pend_nxt = pend_r;
    case (st_r)
      ST_POWER: begin
        // pause, then precharge all before the wake-up refreshes
        if (wait_r == 16'h0) begin
          cmd_nxt = `CMD_PRE;
          addr_nxt = 12'h400;
          wait_nxt = 16'(`T_RP - 1);
          pend_nxt = 2'h2;
          st_nxt = ST_REF;
        end
      end
      ST_REF: begin
        if (wait_r == 16'h0) begin
          cmd_nxt = `CMD_REF;
          wait_nxt = 16'(`T_RFC - 1);
          pend_nxt = pend_r - 2'h1;
          if (pend_r == 2'h1) begin
            st_nxt = init_done_o ? ST_IDLE : ST_LMR;
          end
        end
      end
      ST_LMR: begin
        // all banks are idle here: precharged, then only refreshed
        if (wait_r == 16'h0) begin
          cmd_nxt = `CMD_LMR;
          addr_nxt = `MODE_OP;
          ba_nxt = 2'h0;
          wait_nxt = 16'(`T_MRD - 1);
          done_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wait_r == 16'h0) begin
          if (pend_r != 2'h0) begin
            st_nxt = ST_REF;
          end else if (req_i && ready_o) begin
            // one bank open at a time, so tRRD is always covered
            cmd_nxt = `CMD_ACT;
            ba_nxt = addr_i[21:20];
            addr_nxt = addr_i[19:8];
            we_nxt = we_i;
            col_nxt = addr_i[7:0];
            wd_nxt = wdata_i;
            wm_nxt = wmask_i;
            wait_nxt = 16'(`T_RCD - 1);
            st_nxt = ST_RW;
          end else if (sleep_i) begin
            // power-down only from idle; clock rate never altered
            cke_nxt = 1'b0;
            st_nxt = ST_SLEEP;
          end
        end
      end
      ST_RW: begin
        if (wait_r == 16'h0) begin
          // single word with auto-precharge; next command after T_POST, the longest of tDAL, tRC less tRCD and cl plus one
          cmd_nxt = we_r ? `CMD_WR : `CMD_RD;
          addr_nxt = {1'b0, 1'b1, 2'b00, col_r};
          if (we_r) begin
            cdq_nxt = wd_r;
            cdqoe_nxt = 1'b1;
            dqm_nxt = wm_r;
          end else begin
            rcnt_nxt = 3'(CAS + 1);
          end
          wait_nxt = 16'(T_POST - 1);
          st_nxt = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (!sleep_i || pend_r != 2'h0) begin
          cke_nxt = 1'b1;
          wait_nxt = 16'(`T_PED);
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_POWER;
    endcase
    // a new owed refresh is never lost against a decrement
    if (owe && pend_nxt != 2'h2) begin
      pend_nxt = pend_nxt + 2'h1;
    end
    ready_nxt = (st_nxt == ST_IDLE) && (wait_nxt == 16'h0) && (pend_nxt == 2'h0)
                && done_nxt;
  end

  // controller registers
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_r <= ST_POWER;
      wait_r <= 16'(INIT_CYC - 1);
      tmr_r <= 12'h0;
      pend_r <= 2'h0;
      cke_r <= 1'b1;
      cs_n_r <= 1'b1;
      cmd_r <= `CMD_NOP;
      ba_r <= 2'h0;
      addr_r <= 12'h0;
      dqm_r <= 4'hf;
      cdq_r <= 32'h0;
      cdqoe_r <= 1'b0;
      we_r <= 1'b0;
      col_r <= 8'h0;
      wd_r <= 32'h0;
      wm_r <= 4'h0;
      rcnt_r <= 3'h0;
      ready_o <= 1'b0;
      rdata_o <= 32'h0;
      rvalid_o <= 1'b0;
      init_done_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      wait_r <= wait_nxt;
      tmr_r <= tmr_nxt;
      pend_r <= pend_nxt;
      cke_r <= cke_nxt;
      cs_n_r <= cs_n_nxt;
      cmd_r <= cmd_nxt;
      ba_r <= ba_nxt;
      addr_r <= addr_nxt;
      dqm_r <= dqm_nxt;
      cdq_r <= cdq_nxt;
      cdqoe_r <= cdqoe_nxt;
      we_r <= we_nxt;
      col_r <= col_nxt;
      wd_r <= wd_nxt;
      wm_r <= wm_nxt;
      rcnt_r <= rcnt_nxt;
      ready_o <= ready_nxt;
      rdata_o <= rdata_nxt;
      rvalid_o <= rvalid_nxt;
      init_done_o <= done_nxt;
    end
  end

  assign bus.cke = cke_r;
  assign bus.cs_n = cs_n_r;
  assign bus.cmd = cmd_r;
  assign bus.ba = ba_r;
  assign bus.addr = addr_r;
  assign bus.dqm = dqm_r;
  assign bus.c_dq = cdq_r;
  assign bus.c_dq_oe = cdqoe_r;
endmodule // sdram_ctrl_end

// file: test/sdram_link_props.sv
// concurrent checks on the pin bundle joining controller and memory ends
`timescale 1ns/1ns
`include "sdram_timing_defines.svh"
module sdram_link_props (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [2:0] cmd,
  input wire logic [3:0] dqm,
  input wire logic c_dq_oe,
  input wire logic [3:0] m_dq_oe
);
  // slack over the refresh spacing for a refresh held behind an access
  localparam int REF_LIMIT = `REF_INT_CYC + 16;
  wire logic issued; // command is seen by the memory end
  logic [1:0] refs_r; // refreshes since reset, saturating
  logic [15:0] gap_r; // cycles since the last refresh
  logic gap_on_r; // gap counting starts at the first refresh
  assign issued = !cs_n && cke;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  // refresh bookkeeping; gap stays idle until refreshes begin
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      refs_r <= 2'h0;
      gap_r <= 16'h0;
      gap_on_r <= 1'b0;
    end else if (issued && cmd == `CMD_REF) begin
      refs_r <= (refs_r == 2'h2) ? 2'h2 : refs_r + 2'h1;
      gap_r <= 16'h0;
      gap_on_r <= 1'b1;
    end else if (gap_on_r) begin
      gap_r <= gap_r + 16'h1;
    end
  end

  act_rd_gap_a: assert property (issued && cmd == `CMD_ACT |=>
    cmd != `CMD_RD && cmd != `CMD_WR) else $error("read or write too soon after activate");
  act_bank_gap_a: assert property (issued && cmd == `CMD_ACT |=> cmd != `CMD_ACT)
    else $error("activates too close together");
  act_cycle_a: assert property (issued && cmd == `CMD_ACT |=> (cmd != `CMD_ACT)[*6])
    else $error("row cycle time broken");
  wr_data_a: assert property (issued && cmd == `CMD_WR |-> c_dq_oe ##1 !c_dq_oe)
    else $error("write data not driven with the write command");
  wr_pre_gap_a: assert property (issued && cmd == `CMD_WR |=> (cmd != `CMD_PRE)[*2])
    else $error("precharge inside write recovery");
  wr_act_gap_a: assert property (issued && cmd == `CMD_WR |=> (cmd != `CMD_ACT)[*3])
    else $error("activate too soon after write data");
  mode_gap_a: assert property (issued && cmd == `CMD_LMR |=>
    cmd != `CMD_ACT && cmd != `CMD_REF) else $error("command too soon after mode load");
  rd_mask_a: assert property (dqm != 4'h0 |-> ##2 (m_dq_oe & $past(dqm, 2)) == 4'h0)
    else $error("masked read lane still driven");
  rd_latency_a: assert property (issued && cmd == `CMD_RD && dqm == 4'h0 |->
    ##1 m_dq_oe == 4'h0 ##1 m_dq_oe == 4'hf ##1 m_dq_oe == 4'h0)
    else $error("read data out of its latency slot");
  init_ref_a: assert property (issued && cmd == `CMD_ACT |-> refs_r == 2'h2)
    else $error("activate before the two start-up refreshes");
  ref_gap_a: assert property (gap_r < REF_LIMIT)
    else $error("refresh interval exceeded");

  cover property (issued && cmd == `CMD_RD);
  cover property (issued && cmd == `CMD_WR && dqm != 4'h0);
  cover property (issued && cmd == `CMD_REF && refs_r == 2'h2);
  cover property ($fell(cke));
endmodule // sdram_link_props

// file: test/tb_top.sv
// self-checking bench joining controller end and memory end
`timescale 1ns/1ns
`include "sdram_timing_defines.svh"
module tb_top;
  logic mclk_i, nrst_i, req_i, we_i, sleep_i, ready_o, rvalid_o, init_done_o, power_down_o;
  logic [21:0] addr_i; // {bank, row, col}
  logic [31:0] wdata_i, rdata_o;
  logic [3:0] wmask_i, bank_open_o;
  logic [2:0] cas_lat_o;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0, n_ref = 0, last_act = 0, last_cas = 0, ref_at = 0, ref_prev = 0;
  logic [31:0] wr_word; // wire level seen with the last write
  logic [3:0] wr_mask; // masks seen with the last write

  sdram_bus_if bus_if ();
  // short power-up pause keeps the run brief
  sdram_ctrl_end #(.INIT_CYC(20), .AT_GRADE(1'b0)) u_sdram_ctrl_end (.mclk_i(mclk_i),
    .nrst_i(nrst_i), .bus(bus_if), .req_i(req_i), .we_i(we_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wmask_i(wmask_i), .sleep_i(sleep_i), .ready_o(ready_o),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .init_done_o(init_done_o));
  sdram_mem_end u_sdram_mem_end (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(bus_if),
    .bank_open_o(bank_open_o), .power_down_o(power_down_o), .cas_lat_o(cas_lat_o));
  sdram_link_props u_sdram_link_props (.mclk_i(mclk_i), .nrst_i(nrst_i), .cke(bus_if.cke),
    .cs_n(bus_if.cs_n), .cmd(bus_if.cmd), .dqm(bus_if.dqm), .c_dq_oe(bus_if.c_dq_oe),
    .m_dq_oe(bus_if.m_dq_oe));

  // 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // wire monitor: logs when commands land and what rides with writes
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (nrst_i && !bus_if.cs_n && bus_if.cke) begin
      case (bus_if.cmd)
        `CMD_REF: begin
          n_ref <= n_ref + 1;
          ref_prev <= ref_at;
          ref_at <= cyc;
        end
        `CMD_ACT: last_act <= cyc;
        `CMD_RD: last_cas <= cyc;
        `CMD_WR: begin
          last_cas <= cyc;
          wr_word <= bus_if.dq_bus;
          wr_mask <= bus_if.dqm;
        end
        default: ; // other commands carry nothing logged
      endcase
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one request, held for the single edge that takes it
  task automatic access(input logic we, input logic [21:0] a, input logic [31:0] d,
                        input logic [3:0] m);
    int n;
    n = 0;
    @(negedge mclk_i);
    while (ready_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    check({31'h0, ready_o}, 32'h1);
    req_i = 1'b1;
    we_i = we;
    addr_i = a;
    wdata_i = d;
    wmask_i = m;
    @(negedge mclk_i);
    req_i = 1'b0;
  endtask

  // write, then judge what crossed the wire with it
  task automatic wr(input logic [21:0] a, input logic [31:0] d, input logic [3:0] m);
    access(1'b1, a, d, m);
    repeat (3) @(negedge mclk_i);
    check(wr_word, d);
    check({28'h0, wr_mask}, {28'h0, m});
    check(32'(last_cas - last_act), 32'(`T_RCD));
  endtask

  // read and compare the returned word; the row must close afterwards
  task automatic rd(input logic [21:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    access(1'b0, a, 32'h0, 4'h0);
    while (rvalid_o !== 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    check({31'h0, rvalid_o}, 32'h1);
    check(32'(n), 32'(`T_RCD + `CAS_LAT + 1));
    check(rdata_o, exp);
    check(32'(last_cas - last_act), 32'(`T_RCD));
    repeat (4) @(negedge mclk_i);
    check({28'h0, bank_open_o}, 32'h0);
  endtask

  task automatic t_init();
    int n;
    n = 0;
    while (init_done_o !== 1'b1 && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
    check({31'h0, init_done_o}, 32'h1);
    check(32'(n_ref), 32'h2);
    check({29'h0, cas_lat_o}, 32'h2);
  endtask

  // masked bytes keep their old contents
  task automatic t_mask();
    wr(22'h000000, 32'h11223344, 4'h0);
    wr(22'h000000, 32'haabbccdd, 4'h5);
    rd(22'h000000, 32'haa22cc44);
  endtask

  // every bank in turn, requests issued as soon as taken
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      wr({b[1:0], 12'(b), 8'(b)}, 32'h5a000000 | 32'(b), 4'h0);
    end
    for (int b = 0; b < 4; b++) begin
      rd({b[1:0], 12'(b), 8'(b)}, 32'h5a000000 | 32'(b));
    end
  endtask

  // power-down entry and exit follow the clock enable by one edge
  task automatic t_sleep();
    int n;
    n = 0;
    sleep_i = 1'b1;
    while (bus_if.cke !== 1'b0 && n < 50) begin
      @(negedge mclk_i);
      n++;
    end
    repeat (2) @(negedge mclk_i);
    check({31'h0, power_down_o}, 32'h1);
    sleep_i = 1'b0;
    n = 0;
    while (bus_if.cke !== 1'b1 && n < 50) begin
      @(negedge mclk_i);
      n++;
    end
    repeat (2) @(negedge mclk_i);
    check({31'h0, power_down_o}, 32'h0);
    rd({2'h3, 12'h3, 8'h3}, 32'h5a000003);
  endtask

  // two idle refreshes are one refresh interval apart
  task automatic t_refresh();
    int n, start;
    n = 0;
    start = n_ref;
    while (n_ref < start + 2 && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    check(32'(n_ref - start), 32'h2);
    check(32'(ref_at - ref_prev), 32'(`REF_INT_CYC));
  endtask

  initial begin
    nrst_i = 1'b0;
    req_i = 1'b0;
    we_i = 1'b0;
    addr_i = 22'h0;
    wdata_i = 32'h0;
    wmask_i = 4'h0;
    sleep_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    nrst_i = 1'b1;
    t_init();
    t_mask();
    t_banks();
    t_sleep();
    t_refresh();
    end_of_test();
  end

  // a hang is cut short well past the expected run of some 3200 cycles
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule // tb_top
